// ===== rtl/intc_defs.svh
// Register map, field positions, reset values and vectors of the interrupt flag block
`ifndef INTC_DEFS_SVH
`define INTC_DEFS_SVH

`define OFS_MAIN             32'h0000_0000
`define OFS_EDGE_PRIORITY    32'h0000_0004
`define OFS_EXTERNAL_PINS    32'h0000_0008
`define OFS_PERIPH_FLAGS     32'h0000_000c
`define OFS_RESET_CONTROL    32'h0000_0010

`define RST_MAIN_ENABLES     5'h00
`define RST_EDGE_PRIORITY    8'hff
`define RST_EXT_CONTROL      5'h18
`define RST_PRIORITY_MODE    1'b0

`define BIT_GLOBAL_HIGH      7
`define BIT_PERIPH_LOW       6
`define BIT_TMR0_ENABLE      5
`define BIT_INT0_ENABLE      4
`define BIT_PORT_ENABLE      3
`define BIT_TMR0_FLAG        2
`define BIT_INT0_FLAG        1
`define BIT_PORT_FLAG        0
`define BIT_PULLUP_DISABLE   7
`define BIT_EDGE_PIN0        6
`define BIT_TMR0_PRIORITY    2
`define BIT_INT3_PRIORITY    1
`define BIT_PORT_PRIORITY    0
`define BIT_INT2_PRIORITY    7
`define BIT_INT1_PRIORITY    6
`define BIT_INT3_ENABLE      5
`define BIT_INT2_ENABLE      4
`define BIT_INT1_ENABLE      3
`define BIT_INT3_FLAG        2
`define BIT_INT2_FLAG        1
`define BIT_INT1_FLAG        0
`define BIT_PRIORITY_MODE    7

`define FLAG_COUNT           12
`define FI_TMR0              0
`define FI_INT0              1
`define FI_PORT              2
`define FI_INT1              3
`define FI_INT2              4
`define FI_INT3              5
`define FI_TMR1              6
`define FI_TMR2              7
`define FI_CCP1              8
`define FI_SSP               9
`define FI_AD                10
`define FI_PSP               11

`define VECTOR_HIGH          24'h00_0008
`define VECTOR_LOW           24'h00_0018

`endif

// ===== rtl/intc_pkg.sv
// Types shared by the interrupt flag block
package intc_pkg;
    typedef logic [7:0] reg8_t;
    typedef enum logic [1:0] {ACC_IDLE, ACC_WRITE, ACC_READ_LATE} access_t;
endpackage

// ===== rtl/flag_bank_if.sv
// Set, write and value signals of the sticky flag bank
`timescale 1ns/10ps
interface flag_bank_if #(parameter int WIDTH = 1);
    logic [WIDTH-1:0] set;
    logic [WIDTH-1:0] wrEn;
    logic [WIDTH-1:0] wrVal;
    logic [WIDTH-1:0] value;
    modport bank (
        input  set,
        input  wrEn,
        input  wrVal,
        output value
    );
    modport owner (
        output set,
        output wrEn,
        output wrVal,
        input  value
    );
endinterface

// ===== rtl/pin_edge_detect.sv
// Synchronised external pin with selectable active edge, one-cycle event out
`timescale 1ns/10ps
module pin_edge_detect (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic clkEn,
    input  wire logic pin,
    input  wire logic risingSel,
    output logic      edgeSeen
);
    logic syncFirst;
    logic syncSecond;
    logic previous;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncFirst  <= 1'b0;
            syncSecond <= 1'b0;
            previous   <= 1'b0;
        end else if (clkEn) begin
            syncFirst  <= pin;
            syncSecond <= syncFirst;
            previous   <= syncSecond;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            edgeSeen <= 1'b0;
        end else if (clkEn) begin
            edgeSeen <= risingSel ? (syncSecond & ~previous) : (~syncSecond & previous);
        end
    end
endmodule

// ===== rtl/sticky_flag_bank.sv
// Sticky flags: hardware sets, software writes, a set beats a same-cycle clear
`timescale 1ns/10ps
module sticky_flag_bank (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       clkEn,
    flag_bank_if.bank       flags
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags.value <= '0;
        end else if (clkEn) begin
            for (int i = 0; i < $bits(flags.value); i++) begin
                if (flags.set[i]) begin
                    flags.value[i] <= 1'b1;
                end else if (flags.wrEn[i]) begin
                    flags.value[i] <= flags.wrVal[i];
                end
            end
        end
    end
endmodule

// ===== rtl/interrupt_control_flag_regs.sv
// Interrupt control, edge/priority and first peripheral flag registers on an AHB-Lite slave
//
// Summary of operation
// - Every flag sets on its event regardless of its enable and the global enables.
// - Priority mode off: main bit 7 set enables unmasked interrupts, clear disables all.
// - Priority mode on: main bit 7 set enables high-priority interrupts, clear disables all.
// - Priority mode off: main bit 6 enables or disables all peripheral interrupts.
// - Priority mode on: main bit 6 enables or disables low-priority interrupts.
// - Main bits 5..0: timer-0, pin 0, port-change enables, then their three flags.
// - Port-change flag sets while upper port pins mismatch; a port read ends the mismatch.
// - Software-cleared flags stay set until software writes zero to them.
// - Edge register bit 7 disables all pull-ups; clear lets each follow its latch bit.
// - Edge register bits 6..3 pick pin 0..3 edge: one rising, zero falling.
// - Edge register bits 2..0: timer-0, pin 3, port-change priority, one is high.
// - Pin register: pin 2,1 priorities, pin 3,2,1 enables, pin 3,2,1 flags.
// - Peripheral flag bit 7 sets on parallel port access, only in microcontroller mode.
// - Peripheral flag bit 6 sets when a conversion completes; software clears it.
// - Peripheral flag bit 5 is read-only and mirrors the receive buffer being full.
// - Peripheral flag bit 4 is read-only and mirrors the transmit buffer being empty.
// - Peripheral flag bit 3 sets when a sync serial transfer completes.
// - Peripheral flag bit 2 sets on capture or compare, never in PWM mode.
// - Peripheral flag bit 1 sets on timer-2 match, bit 0 on timer-1 overflow.
// - Reset-control bit 7 turns priority mode on; off, priority bits have no effect.
// - High requests vector to 000008h, low to 000018h; compatibility uses 000008h only.
`timescale 1ns/10ps
`include "intc_defs.svh"
module interrupt_control_flag_regs (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clkEn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Core interrupt sources
    input  wire logic        timerZeroOverflow,
    input  wire logic [3:0]  extPin,
    input  wire logic [3:0]  portBPin,
    input  wire logic        portBRead,
    input  wire logic [7:0]  portBLatch,
    output logic [7:0]       pullupOn,
    // Peripheral sources
    input  wire logic        parallelPortAccess,
    input  wire logic        microcontrollerMode,
    input  wire logic        conversionDone,
    input  wire logic        serialRxBufferFull,
    input  wire logic        serialTxBufferEmpty,
    input  wire logic        syncSerialDone,
    input  wire logic        captureCompareOneEvent,
    input  wire logic        captureComparePwmMode,
    input  wire logic        timerTwoMatch,
    input  wire logic        timerOneOverflow,
    input  wire logic [7:0]  peripheralEnable,
    input  wire logic [7:0]  peripheralPriority,
    // Core side
    output logic             highRequest,
    output logic             lowRequest,
    output logic [23:0]      vectorAddress
);
    logic [7:3]        mainEnables;
    intc_pkg::reg8_t   edgePriority;
    logic [7:3]        extControl;
    logic              priorityModeEnable;
    logic              rxFullMirror;
    logic              txEmptyMirror;
    intc_pkg::access_t phase;
    logic [31:0]       dataAddr;
    logic              addrTaken;
    logic              writeMain;
    logic              writeEdge;
    logic              writeExt;
    logic              writePeriph;
    logic              writeReset;
    logic [3:0]        pinEvent;
    logic [3:0]        portSyncFirst;
    logic [3:0]        portSyncSecond;
    logic [3:0]        portReference;
    logic              portPrimed;
    logic              portMismatch;
    intc_pkg::reg8_t   mainValue;
    intc_pkg::reg8_t   extValue;
    intc_pkg::reg8_t   periphValue;
    intc_pkg::reg8_t   periphActive;
    logic              coreHigh;
    logic              coreLow;
    logic              next_high;
    logic              next_low;
    logic              compatRequest;

    flag_bank_if #(.WIDTH(`FLAG_COUNT)) flags ();

    sticky_flag_bank flagBank (
        .clk   (clk),
        .rst_n (rst_n),
        .clkEn (clkEn),
        .flags (flags)
    );

    // External pins, each with its own selected edge
    for (genvar i = 0; i < 4; i++) begin : gPin
        pin_edge_detect edgeDetect (
            .clk       (clk),
            .rst_n     (rst_n),
            .clkEn     (clkEn),
            .pin       (extPin[i]),
            .risingSel (edgePriority[`BIT_EDGE_PIN0 - i]),
            .edgeSeen  (pinEvent[i])
        );
    end

    // Bus address phase and data phase tracking
    assign addrTaken = hsel & htrans[1] & hready;

    always_comb begin
        writeMain   = 1'b0;
        writeEdge   = 1'b0;
        writeExt    = 1'b0;
        writePeriph = 1'b0;
        writeReset  = 1'b0;
        if (phase == intc_pkg::ACC_WRITE) begin
            if (dataAddr == `OFS_MAIN) begin
                writeMain = 1'b1;
            end else if (dataAddr == `OFS_EDGE_PRIORITY) begin
                writeEdge = 1'b1;
            end else if (dataAddr == `OFS_EXTERNAL_PINS) begin
                writeExt = 1'b1;
            end else if (dataAddr == `OFS_PERIPH_FLAGS) begin
                writePeriph = 1'b1;
            end else if (dataAddr == `OFS_RESET_CONTROL) begin
                writeReset = 1'b1;
            end
        end
    end

    function automatic logic [31:0] readMux(input logic [31:0] addr);
        logic [31:0] value;
        value = '0;
        if (addr == `OFS_MAIN) begin
            value[7:0] = mainValue;
        end else if (addr == `OFS_EDGE_PRIORITY) begin
            value[7:0] = edgePriority;
        end else if (addr == `OFS_EXTERNAL_PINS) begin
            value[7:0] = extValue;
        end else if (addr == `OFS_PERIPH_FLAGS) begin
            value[7:0] = periphValue;
        end else if (addr == `OFS_RESET_CONTROL) begin
            value[`BIT_PRIORITY_MODE] = priorityModeEnable;
        end
        return value;
    endfunction

    // A read right behind a write waits one cycle so it sees the written value
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase     <= intc_pkg::ACC_IDLE;
            dataAddr  <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= '0;
        end else if (clkEn) begin
            if (addrTaken) begin
                dataAddr <= haddr;
                if (hwrite) begin
                    phase <= intc_pkg::ACC_WRITE;
                end else if (phase == intc_pkg::ACC_WRITE) begin
                    phase     <= intc_pkg::ACC_READ_LATE;
                    hreadyout <= 1'b0;
                end else begin
                    phase  <= intc_pkg::ACC_IDLE;
                    hrdata <= readMux(haddr);
                end
            end else if (phase == intc_pkg::ACC_READ_LATE) begin
                phase     <= intc_pkg::ACC_IDLE;
                hreadyout <= 1'b1;
                hrdata    <= readMux(dataAddr);
            end else begin
                phase <= intc_pkg::ACC_IDLE;
            end
        end
    end

    // Control bits written by software
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mainEnables        <= `RST_MAIN_ENABLES;
            edgePriority       <= `RST_EDGE_PRIORITY;
            extControl         <= `RST_EXT_CONTROL;
            priorityModeEnable <= `RST_PRIORITY_MODE;
        end else if (clkEn) begin
            if (writeMain) begin
                mainEnables <= hwdata[7:3];
            end
            if (writeEdge) begin
                edgePriority <= hwdata[7:0];
            end
            if (writeExt) begin
                extControl <= hwdata[7:3];
            end
            if (writeReset) begin
                priorityModeEnable <= hwdata[`BIT_PRIORITY_MODE];
            end
        end
    end

    // Read-only serial buffer status follows the serial port itself
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxFullMirror  <= 1'b0;
            txEmptyMirror <= 1'b0;
        end else if (clkEn) begin
            rxFullMirror  <= serialRxBufferFull;
            txEmptyMirror <= serialTxBufferEmpty;
        end
    end

    // Upper port pins: synchronise, then compare against the value last read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            portSyncFirst  <= '0;
            portSyncSecond <= '0;
        end else if (clkEn) begin
            portSyncFirst  <= portBPin;
            portSyncSecond <= portSyncFirst;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            portReference <= '0;
            portPrimed    <= 1'b0;
        end else if (clkEn) begin
            portPrimed <= 1'b1;
            if (portBRead || !portPrimed) begin
                portReference <= portSyncSecond;
            end
        end
    end

    assign portMismatch = portPrimed && (portSyncSecond != portReference);

    // Flag set terms
    always_comb begin
        flags.set[`FI_TMR0]    = timerZeroOverflow;
        flags.set[`FI_INT0]    = pinEvent[0];
        flags.set[`FI_INT1]    = pinEvent[1];
        flags.set[`FI_INT2]    = pinEvent[2];
        flags.set[`FI_INT3]    = pinEvent[3];
        flags.set[`FI_PORT]    = portMismatch;
        flags.set[`FI_PSP]     = parallelPortAccess & microcontrollerMode;
        flags.set[`FI_AD]      = conversionDone;
        flags.set[`FI_SSP]     = syncSerialDone;
        flags.set[`FI_CCP1]    = captureCompareOneEvent & ~captureComparePwmMode;
        flags.set[`FI_TMR2]    = timerTwoMatch;
        flags.set[`FI_TMR1]    = timerOneOverflow;
    end

    // Flag index order: three main, three pin, six peripheral
    assign flags.wrEn = {{6{writePeriph}}, {3{writeExt}}, {3{writeMain}}};

    assign flags.wrVal = {hwdata[7:6], hwdata[3:0],
                          hwdata[`BIT_INT3_FLAG], hwdata[`BIT_INT2_FLAG], hwdata[`BIT_INT1_FLAG],
                          hwdata[`BIT_PORT_FLAG], hwdata[`BIT_INT0_FLAG], hwdata[`BIT_TMR0_FLAG]};

    // Register images as software sees them
    always_comb begin
        mainValue = {mainEnables, flags.value[`FI_TMR0], flags.value[`FI_INT0], flags.value[`FI_PORT]};
        extValue  = {extControl, flags.value[`FI_INT3], flags.value[`FI_INT2], flags.value[`FI_INT1]};
        periphValue = {flags.value[`FI_PSP], flags.value[`FI_AD], rxFullMirror, txEmptyMirror,
                       flags.value[`FI_SSP], flags.value[`FI_CCP1], flags.value[`FI_TMR2],
                       flags.value[`FI_TMR1]};
    end

    // Request formation
    always_comb begin
        logic tmr0Active;
        logic int0Active;
        logic portActive;
        logic int1Active;
        logic int2Active;
        logic int3Active;
        logic periphHigh;
        logic periphLow;
        tmr0Active   = flags.value[`FI_TMR0] & mainValue[`BIT_TMR0_ENABLE];
        int0Active   = flags.value[`FI_INT0] & mainValue[`BIT_INT0_ENABLE];
        portActive   = flags.value[`FI_PORT] & mainValue[`BIT_PORT_ENABLE];
        int1Active   = flags.value[`FI_INT1] & extValue[`BIT_INT1_ENABLE];
        int2Active   = flags.value[`FI_INT2] & extValue[`BIT_INT2_ENABLE];
        int3Active   = flags.value[`FI_INT3] & extValue[`BIT_INT3_ENABLE];
        periphActive = periphValue & peripheralEnable;
        periphHigh   = |(periphActive & peripheralPriority);
        periphLow    = |(periphActive & ~peripheralPriority);
        // Pin 0 has no priority bit and is always high priority
        coreHigh = (tmr0Active & edgePriority[`BIT_TMR0_PRIORITY]) | int0Active
                 | (portActive & edgePriority[`BIT_PORT_PRIORITY])
                 | (int1Active & extValue[`BIT_INT1_PRIORITY])
                 | (int2Active & extValue[`BIT_INT2_PRIORITY])
                 | (int3Active & edgePriority[`BIT_INT3_PRIORITY]);
        coreLow  = (tmr0Active & ~edgePriority[`BIT_TMR0_PRIORITY])
                 | (portActive & ~edgePriority[`BIT_PORT_PRIORITY])
                 | (int1Active & ~extValue[`BIT_INT1_PRIORITY])
                 | (int2Active & ~extValue[`BIT_INT2_PRIORITY])
                 | (int3Active & ~edgePriority[`BIT_INT3_PRIORITY]);
        compatRequest = mainValue[`BIT_GLOBAL_HIGH]
                      & (tmr0Active | int0Active | portActive | int1Active | int2Active | int3Active
                         | (mainValue[`BIT_PERIPH_LOW] & (|periphActive)));
        if (priorityModeEnable) begin
            next_high = mainValue[`BIT_GLOBAL_HIGH] & (coreHigh | periphHigh);
            next_low  = mainValue[`BIT_GLOBAL_HIGH] & mainValue[`BIT_PERIPH_LOW]
                      & (coreLow | periphLow);
        end else begin
            next_high = compatRequest;
            next_low  = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            highRequest   <= 1'b0;
            lowRequest    <= 1'b0;
            vectorAddress <= `VECTOR_HIGH;
        end else if (clkEn) begin
            highRequest <= next_high;
            lowRequest  <= next_low;
            if (!next_high && next_low) begin
                vectorAddress <= `VECTOR_LOW;
            end else begin
                vectorAddress <= `VECTOR_HIGH;
            end
        end
    end

    // Pull-ups
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pullupOn <= '0;
        end else if (clkEn) begin
            pullupOn <= edgePriority[`BIT_PULLUP_DISABLE] ? '0 : portBLatch;
        end
    end
endmodule

// ===== tb/intc_assertions.sv
// Concurrent checks of bus ready, requests, vector and pull-ups
`timescale 1ns/10ps
module intc_checker (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        clkEn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [7:0]  portBLatch,
    input wire logic [7:0]  pullupOn,
    input wire logic        highRequest,
    input wire logic        lowRequest,
    input wire logic [23:0] vectorAddress
);
    logic       wrPend, puOff, gieHigh, gieLow, prio;
    logic [7:0] wrAddr;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Control bits as software last wrote them
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {wrPend, puOff, gieHigh, gieLow, prio} <= 5'h08;
            wrAddr <= 8'h00;
        end else if (clkEn && hready) begin
            wrPend <= hsel && htrans[1] && hwrite;
            wrAddr <= haddr[7:0];
            if (wrPend && wrAddr == 8'h04) puOff <= hwdata[7];
            if (wrPend && wrAddr == 8'h00) {gieHigh, gieLow} <= hwdata[7:6];
            if (wrPend && wrAddr == 8'h10) prio <= hwdata[7];
        end
    end
    sequence s_puOff; puOff [*2]; endsequence
    sequence s_puOn; !puOff [*2]; endsequence
    sequence s_highOff; !gieHigh [*2]; endsequence
    sequence s_lowOff; !gieLow [*2]; endsequence
    sequence s_compat; !prio [*2]; endsequence
    property p_puOff; s_puOff |-> pullupOn == 8'h00; endproperty
    a_puOff: assert property (p_puOff) else $error("pull-up on while disabled");
    property p_puLatch; s_puOn |-> pullupOn == $past(portBLatch); endproperty
    a_puLatch: assert property (p_puLatch) else $error("pull-up differs from latch");
    property p_highOff; s_highOff |-> !highRequest && !lowRequest; endproperty
    a_highOff: assert property (p_highOff) else $error("request while global off");
    property p_lowOff; s_lowOff |-> !lowRequest; endproperty
    a_lowOff: assert property (p_lowOff) else $error("low request while low off");
    property p_compat; s_compat |-> !lowRequest; endproperty
    a_compat: assert property (p_compat) else $error("low request in compatible mode");
    property p_vecHigh; highRequest || !lowRequest |-> vectorAddress == 24'h000008; endproperty
    a_vecHigh: assert property (p_vecHigh) else $error("high vector wrong");
    property p_vecLow; !highRequest && lowRequest |-> vectorAddress == 24'h000018; endproperty
    a_vecLow: assert property (p_vecLow) else $error("low vector wrong");
    property p_stall; !hreadyout |=> hreadyout; endproperty
    a_stall: assert property (p_stall) else $error("wait state too long");
endmodule
bind interrupt_control_flag_regs intc_checker intc_checker_i (.*);

// ===== tb/periph_model.sv
// Peripheral event sources and first serial port buffer levels
`timescale 1ns/10ps
module periph_model #(parameter int TX_TIME = 20) (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [6:0] fire,
    input wire logic [1:0] serialCmd,
    output logic [6:0]     pulse,
    output logic           rxFull,
    output logic           txEmpty
);
    int txCount;
    // Each requested event becomes one pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) pulse <= '0;
        else pulse <= fire;
    end
    // 1 receives a byte, 2 reads it, 3 loads the transmitter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxFull <= 1'b0;
            txEmpty <= 1'b1;
            txCount <= 0;
        end else begin
            if (serialCmd == 2'h1) rxFull <= 1'b1;
            if (serialCmd == 2'h2) rxFull <= 1'b0;
            if (serialCmd == 2'h3) txCount <= TX_TIME;
            else if (txCount != 0) txCount <= txCount - 1;
            txEmpty <= serialCmd != 2'h3 && txCount <= 1;
        end
    end
endmodule

// ===== tb/tb.sv
// Register-level test of the interrupt control and flag registers
`timescale 1ns/10ps
`include "intc_defs.svh"
module tb;
    logic        clk = '0, rst_n = '0, hsel = '0, hwrite = '0, portBRead = '0;
    logic        microcontrollerMode = '1, captureComparePwmMode = '0;
    logic [1:0]  htrans = '0, serialCmd = '0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata;
    logic [3:0]  extPin = '0, portBPin = '0;
    logic [7:0]  portBLatch = 8'h5a, pullupOn;
    logic [6:0]  fire = '0, pulse;
    logic        hreadyout, highRequest, lowRequest, rxFull, txEmpty;
    logic [23:0] vectorAddress;
    int          miscompares = 0, nCompared = 0;
    logic [7:0]  rstVal [6] = '{8'h00, 8'hff, 8'hc0, 8'h10, 8'h00, 8'h00};
    periph_model periph_model_i (.*);
    interrupt_control_flag_regs interrupt_control_flag_regs_i (
        .*, .clkEn(1'b1), .hsize(3'h2), .hready(hreadyout), .hresp(),
        .timerZeroOverflow(pulse[6]), .parallelPortAccess(pulse[5]), .conversionDone(pulse[4]),
        .syncSerialDone(pulse[3]), .captureCompareOneEvent(pulse[2]), .timerTwoMatch(pulse[1]),
        .timerOneOverflow(pulse[0]), .serialRxBufferFull(rxFull), .serialTxBufferEmpty(txEmpty),
        .peripheralEnable(8'hff), .peripheralPriority(8'h00));
    always #20 clk = ~clk;
    task automatic final_report;
        $display("compared %0d, mismatches %0d", nCompared, miscompares);
        if (miscompares == 0 && nCompared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, got);
        nCompared++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic waitReady;
        int n = 0;
        do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 20);
        if (n >= 20) begin miscompares++; final_report(); end
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, wd, output logic [31:0] rd);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= wr; haddr <= a;
        waitReady();
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
        waitReady();
        rd = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rdChk(input logic [31:0] a, exp, input string what);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(what, exp, r);
    endtask
    task automatic fireEv(input logic [6:0] f);
        fire <= f;
        @(posedge clk);
        fire <= 7'h00;
        repeat (3) @(posedge clk);
    endtask
    task automatic ser(input logic [1:0] c);
        serialCmd <= c;
        @(posedge clk);
        serialCmd <= 2'h0;
        @(posedge clk);
    endtask
    task automatic reqChk(input logic [1:0] exp, input string what);
        repeat (2) @(posedge clk);
        chk(what, {30'h0, exp}, {30'h0, highRequest, lowRequest});
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) rdChk(i * 4, {24'h0, rstVal[i]}, "reset value");
        wr(32'h14, 32'hff);
        rdChk(32'h14, 32'h0, "unmapped");
        fireEv(7'h40);
        rdChk(`OFS_MAIN, 32'h04, "timer flag");
        wr(`OFS_MAIN, 32'h00);
        rdChk(`OFS_MAIN, 32'h00, "timer flag cleared");
        for (int i = 0; i < 6; i++) begin
            fireEv(7'h01 << i);
            rdChk(`OFS_PERIPH_FLAGS, 32'h10 | (32'h1 << (i < 4 ? i : i + 2)), "peripheral flag");
            wr(`OFS_PERIPH_FLAGS, 32'h00);
        end
        microcontrollerMode <= 1'b0;
        captureComparePwmMode <= 1'b1;
        fireEv(7'h24);
        rdChk(`OFS_PERIPH_FLAGS, 32'h10, "gated flags");
        ser(2'h1);
        wr(`OFS_PERIPH_FLAGS, 32'h00);
        rdChk(`OFS_PERIPH_FLAGS, 32'h30, "receive full");
        ser(2'h2);
        rdChk(`OFS_PERIPH_FLAGS, 32'h10, "receive read");
        ser(2'h3);
        rdChk(`OFS_PERIPH_FLAGS, 32'h00, "transmit loaded");
        repeat (25) @(posedge clk);
        wr(`OFS_PERIPH_FLAGS, 32'h00);
        rdChk(`OFS_PERIPH_FLAGS, 32'h10, "transmit empty");
        portBPin <= 4'h8;
        repeat (6) @(posedge clk);
        wr(`OFS_MAIN, 32'h00);
        rdChk(`OFS_MAIN, 32'h01, "mismatch persists");
        portBRead <= 1'b1;
        @(posedge clk);
        portBRead <= 1'b0;
        wr(`OFS_MAIN, 32'h00);
        rdChk(`OFS_MAIN, 32'h00, "mismatch ended");
        for (int p = 0; p < 4; p++) begin
            extPin[p] <= 1'b1;
            repeat (6) @(posedge clk);
            rdChk(`OFS_MAIN, p == 0 ? 32'h02 : 32'h00, "pin zero flag");
            rdChk(`OFS_EXTERNAL_PINS, 32'hc0 | ((32'h1 << p) >> 1), "pin flags");
            wr(`OFS_MAIN, 32'h00);
            wr(`OFS_EXTERNAL_PINS, 32'hc0);
        end
        wr(`OFS_EDGE_PRIORITY, 32'h80);
        repeat (6) @(posedge clk);
        wr(`OFS_MAIN, 32'h00);
        wr(`OFS_EXTERNAL_PINS, 32'hc0);
        extPin <= 4'h0;
        repeat (6) @(posedge clk);
        rdChk(`OFS_MAIN, 32'h02, "pin zero falling");
        rdChk(`OFS_EXTERNAL_PINS, 32'hc7, "pins falling");
        wr(`OFS_EXTERNAL_PINS, 32'hc0);
        fireEv(7'h40);
        wr(`OFS_MAIN, 32'h24);
        reqChk(2'h0, "global off");
        wr(`OFS_MAIN, 32'ha4);
        reqChk(2'h2, "compatible");
        wr(`OFS_RESET_CONTROL, 32'h80);
        reqChk(2'h0, "low enable off");
        wr(`OFS_MAIN, 32'he4);
        reqChk(2'h1, "low priority");
        chk("vector", 32'h18, {8'h0, vectorAddress});
        portBLatch <= 8'ha5;
        wr(`OFS_EDGE_PRIORITY, 32'h04);
        reqChk(2'h3, "high priority");
        chk("pull-ups", 32'ha5, {24'h0, pullupOn});
        final_report();
    end
endmodule
